// ### hdl/bridge_arbiter_ctl.sv
/*
  Bridge control and pci arbiter: two control registers over AHB-Lite, i/o
  claim decode, subtractive decode timing, grant logic with retry masking,
  parking, locking and the isa master hand-off sequence.
  Assumes pci pins arrive asynchronously and cycle decode inputs are on MCLK_IN.
*/
`timescale 1ns/1ps
// How it works
// - alias bit 0 claims 90h-9Fh as page aliases; 1 forwards them to isa
// - port 92h is always fully decoded as its own register
// - intack enable clear ignores inta cycles but still serves controller registers
// - unclaimed cycle goes to isa if devsel inactive at chosen sample point
// - posted write buffer enable bit resets to 0 and gates posting
// - isa master line buffer: 0 single transaction, 1 eight-byte mode
// - dma line buffer: 0 single transaction, 1 multi-byte mode
// - arbiter control bits 7:5 always read as zero
// - retried initiator is masked for 16, 32 or 64 clocks, or never
// - bus park set grants the host line when the bus is idle
// - park clear drives ad, c/be and par itself on idle
// - bus lock mode grants only the lock owner, or with park set the host line, while a locked transaction runs
// - resource lock mode keeps granting other agents normally
// - guaranteed access gets pci then memory before granting isa
// - without guaranteed access, isa is granted first, pci afterwards
module bridge_arbiter_ctl
  import bridge_ctl_pkg::*;
#(
  parameter int NEXT = 4
) (
  input  wire logic            MCLK_IN,
  input  wire logic            RST_N_IN,
  input  wire logic            HSEL_IN,
  input  wire logic [31:0]     HADDR_IN,
  input  wire logic [1:0]      HTRANS_IN,
  input  wire logic            HWRITE_IN,
  input  wire logic [2:0]      HSIZE_IN,
  input  wire logic [31:0]     HWDATA_IN,
  input  wire logic            HREADY_IN,
  output logic                 HREADYOUT_OUT,
  output logic                 HRESP_OUT,
  output logic      [31:0]     HRDATA_OUT,
  input  wire logic [NEXT-1:0] REQ_N_IN,
  input  wire logic            HOST_REQUEST_LINE_N_IN,
  input  wire logic            FRAME_N_IN,
  input  wire logic            IRDY_N_IN,
  input  wire logic            TRDY_N_IN,
  input  wire logic            STOP_N_IN,
  input  wire logic            DEVSEL_N_IN,
  input  wire logic            LOCK_N_IN,
  input  wire logic            ISA_MASTER_REQ_IN,
  input  wire logic            MEM_GNT_IN,
  input  wire logic            CYC_VALID_IN,
  input  wire logic            CYC_IO_IN,
  input  wire logic            CYC_INTA_IN,
  input  wire logic [15:0]     CYC_ADDR_IN,
  output logic      [NEXT-1:0] GNT_N_OUT,
  output logic                 HOST_GNT_N_OUT,
  output logic                 BUS_DRIVE_OE_N_OUT,
  output logic                 ISA_GNT_OUT,
  output logic                 MEM_REQ_OUT,
  output logic                 CLAIM_PAGE_OUT,
  output logic                 CLAIM_PORT92_OUT,
  output logic                 CLAIM_PIC_OUT,
  output logic                 CLAIM_INTA_OUT,
  output logic                 FORWARD_ISA_OUT,
  output logic                 POSTED_WRITE_BUFFER_ENABLE_OUT,
  output logic                 ISA_MASTER_LINEBUF_MODE_OUT,
  output logic                 DMA_LINEBUF_MODE_OUT
);

  localparam int NM = NEXT + 2; // bit 0 bridge, bit 1 host, then external

  // pin synchronisers, first stage read only by the second
  logic [NEXT+6:0] pin_s1_ff;
  logic [NEXT+6:0] pin_s2_ff;
  wire  [NEXT+6:0] pin_raw = {~REQ_N_IN, ~HOST_REQUEST_LINE_N_IN, MEM_GNT_IN, ~FRAME_N_IN, ~IRDY_N_IN,
                              ~TRDY_N_IN, ~STOP_N_IN, ~DEVSEL_N_IN};
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
    end else begin
      pin_s1_ff <= pin_raw;
      pin_s2_ff <= pin_s1_ff;
    end
  end
  logic lock_s1_ff;
  logic lock_s2_ff;
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      lock_s1_ff <= 1'b0;
      lock_s2_ff <= 1'b0;
    end else begin
      lock_s1_ff <= ~LOCK_N_IN;
      lock_s2_ff <= lock_s1_ff;
    end
  end

  pci_bus_t bus;
  assign bus.devsel = pin_s2_ff[0];
  assign bus.stop   = pin_s2_ff[1];
  assign bus.trdy   = pin_s2_ff[2];
  assign bus.irdy   = pin_s2_ff[3];
  assign bus.frame  = pin_s2_ff[4];
  assign bus.lock   = lock_s2_ff;
  wire             mem_gnt  = pin_s2_ff[5];
  wire             host_req = pin_s2_ff[6];
  wire [NEXT-1:0]  ext_req  = pin_s2_ff[NEXT+6:7];
  wire             bus_idle = !bus.frame && !bus.irdy;

  // ahb-lite slave: address phase captured, zero wait data phase
  logic [7:0]  bridge_ctrl_ff;
  logic [7:0]  arbiter_ctrl_ff;
  logic        wr_pend_ff;
  logic [31:0] wr_addr_ff;
  wire         ahb_go  = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
  wire [31:0]  rd_word = (HADDR_IN == ADDR_BRIDGE_CTRL)  ? {24'h0, bridge_ctrl_ff} :
                         (HADDR_IN == ADDR_ARBITER_CTRL) ? {24'h0, arbiter_ctrl_ff} : 32'h0;
  wire         wr_brg  = wr_pend_ff && (wr_addr_ff == ADDR_BRIDGE_CTRL);
  wire         wr_arb  = wr_pend_ff && (wr_addr_ff == ADDR_ARBITER_CTRL);
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      wr_pend_ff    <= 1'b0;
      wr_addr_ff    <= 32'h0;
      HRDATA_OUT    <= 32'h0;
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT     <= 1'b0;
    end else begin
      wr_pend_ff <= ahb_go && HWRITE_IN;
      if (ahb_go) begin
        wr_addr_ff <= HADDR_IN;
        HRDATA_OUT <= HWRITE_IN ? 32'h0 : rd_word;
      end
    end
  end

  // control registers, reserved bits held at zero
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      bridge_ctrl_ff  <= RST_BRIDGE_CTRL;
      arbiter_ctrl_ff <= RST_ARBITER_CTRL;
    end else begin
      if (wr_brg)
        bridge_ctrl_ff <= HWDATA_IN[7:0] & MASK_BRIDGE_CTRL;
      if (wr_arb)
        arbiter_ctrl_ff <= HWDATA_IN[7:0] & MASK_ARBITER_CTRL;
    end
  end

  wire       page_alias = bridge_ctrl_ff[BIT_PAGE_ALIAS];
  wire       intack_en  = bridge_ctrl_ff[BIT_INTACK_EN];
  wire [1:0] sample_sel = bridge_ctrl_ff[POS_SAMPLE_POINT +: 2];
  wire [1:0] retry_sel  = arbiter_ctrl_ff[POS_RETRY_TIMER +: 2];
  wire       park_en    = arbiter_ctrl_ff[BIT_BUS_PARK];
  wire       bus_lock   = arbiter_ctrl_ff[BIT_LOCK_SCOPE];
  wire       guaranteed = arbiter_ctrl_ff[BIT_GUARANTEED];

  // positive i/o decode
  wire io_cyc     = CYC_VALID_IN && CYC_IO_IN;
  wire hit_92     = io_cyc && (CYC_ADDR_IN == IO_PORT92);
  wire hit_page   = io_cyc && (CYC_ADDR_IN[15:4] == IO_PAGE_BASE[15:4]);
  wire hit_alias  = io_cyc && !page_alias && (CYC_ADDR_IN[15:4] == IO_PORT92[15:4]) && !hit_92;
  wire hit_pic    = io_cyc && ((CYC_ADDR_IN[15:1] == IO_PIC1_BASE[15:1]) ||
                               (CYC_ADDR_IN[15:1] == IO_PIC2_BASE[15:1]));
  wire hit_inta   = CYC_VALID_IN && CYC_INTA_IN && intack_en;
  wire hit_any    = hit_92 || hit_page || hit_alias || hit_pic || hit_inta;

  // subtractive decode: clocks since the address phase
  logic [2:0] cyc_cnt_ff;
  logic       frame_d_ff;
  logic       claimed_ff;
  wire  [2:0] sample_clk = (sample_sel == SUBTRACTIVE_SAMPLE_POINT_FAST)    ? CLK_SUBTRACTIVE_SAMPLE_POINT_FAST :
                           (sample_sel == SUBTRACTIVE_SAMPLE_POINT_TYPICAL) ? CLK_SUBTRACTIVE_SAMPLE_POINT_TYPICAL : CLK_SUBTRACTIVE_SAMPLE_POINT_SLOW;
  wire        frame_rise = bus.frame && !frame_d_ff;
  wire        at_sample  = (cyc_cnt_ff == sample_clk);
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      frame_d_ff       <= 1'b0;
      cyc_cnt_ff       <= 3'h0;
      claimed_ff       <= 1'b0;
      FORWARD_ISA_OUT  <= 1'b0;
      CLAIM_PAGE_OUT   <= 1'b0;
      CLAIM_PORT92_OUT <= 1'b0;
      CLAIM_PIC_OUT    <= 1'b0;
      CLAIM_INTA_OUT   <= 1'b0;
    end else begin
      frame_d_ff       <= bus.frame;
      cyc_cnt_ff       <= frame_rise ? 3'd1 : (cyc_cnt_ff != 3'h0 && cyc_cnt_ff != 3'd7) ? cyc_cnt_ff + 3'd1 : 3'h0;
      claimed_ff       <= frame_rise ? hit_any : (claimed_ff || hit_any);
      FORWARD_ISA_OUT  <= at_sample && !bus.devsel && !claimed_ff && !hit_any;
      CLAIM_PAGE_OUT   <= hit_page || hit_alias;
      CLAIM_PORT92_OUT <= hit_92;
      CLAIM_PIC_OUT    <= hit_pic;
      CLAIM_INTA_OUT   <= hit_inta;
    end
  end

  // mode outputs follow the control register
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      POSTED_WRITE_BUFFER_ENABLE_OUT <= 1'b0;
      ISA_MASTER_LINEBUF_MODE_OUT    <= 1'b0;
      DMA_LINEBUF_MODE_OUT           <= 1'b0;
    end else begin
      POSTED_WRITE_BUFFER_ENABLE_OUT <= bridge_ctrl_ff[BIT_POSTED_WR_EN];
      ISA_MASTER_LINEBUF_MODE_OUT    <= bridge_ctrl_ff[BIT_ISA_LINEBUF];
      DMA_LINEBUF_MODE_OUT           <= bridge_ctrl_ff[BIT_DMA_LINEBUF];
    end
  end

  // isa master hand-off
  isa_state_t isa_st_ff;
  isa_state_t nxt_isa_st;
  logic [NM-1:0] gnt_n_ff;
  wire  [NM-1:0] gnt = ~gnt_n_ff;
  always_comb begin
    nxt_isa_st = isa_st_ff;
    case (isa_st_ff)
      ISA_IDLE:     if (ISA_MASTER_REQ_IN) nxt_isa_st = guaranteed ? ISA_GET_PCI : ISA_OWNED;
      ISA_GET_PCI:  if (gnt[0]) nxt_isa_st = ISA_GET_MEM;
      ISA_GET_MEM:  if (mem_gnt) nxt_isa_st = ISA_OWNED;
      ISA_OWNED:    if (!ISA_MASTER_REQ_IN) nxt_isa_st = ISA_IDLE;
                    else if (!guaranteed) nxt_isa_st = ISA_LATE_PCI;
      ISA_LATE_PCI: if (!ISA_MASTER_REQ_IN) nxt_isa_st = ISA_IDLE;
      default:      nxt_isa_st = ISA_IDLE;
    endcase
  end
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      isa_st_ff   <= ISA_IDLE;
      ISA_GNT_OUT <= 1'b0;
      MEM_REQ_OUT <= 1'b0;
    end else begin
      isa_st_ff   <= nxt_isa_st;
      ISA_GNT_OUT <= (nxt_isa_st == ISA_OWNED) || (nxt_isa_st == ISA_LATE_PCI);
      MEM_REQ_OUT <= (nxt_isa_st == ISA_GET_MEM) || (nxt_isa_st == ISA_OWNED && guaranteed);
    end
  end
  wire bridge_req = (isa_st_ff == ISA_GET_PCI) || (isa_st_ff == ISA_GET_MEM) ||
                    (isa_st_ff == ISA_LATE_PCI) || (isa_st_ff == ISA_OWNED && guaranteed);

  // retry of the current owner: stop with devsel and no trdy
  wire [NM-1:0] retry_ev = (bus.stop && bus.devsel && !bus.trdy) ? gnt : '0;
  wire [NM-1:0] masked;
  retry_mask #(.NREQ(NM)) u_retry (
    .clk_in       (MCLK_IN),
    .rst_n_in     (RST_N_IN),
    .timer_sel_in (retry_sel),
    .retry_in     (retry_ev),
    .masked_out   (masked)
  );

  // lock tracking: owner recorded when a locked transaction starts
  logic          locked_ff;
  logic [NM-1:0] lock_owner_ff;
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      locked_ff     <= 1'b0;
      lock_owner_ff <= '0;
    end else if (!locked_ff && bus.lock && bus.frame) begin
      locked_ff     <= 1'b1;
      lock_owner_ff <= gnt;
    end else if (locked_ff && !bus.lock && bus_idle) begin
      locked_ff     <= 1'b0;
    end
  end

  // lowest index wins
  function automatic logic [NM-1:0] pick(input logic [NM-1:0] v);
    pick = v & (~v + 1'b1);
  endfunction

  // grant update only while the bus is idle
  wire [NM-1:0] req_all  = {ext_req, host_req, bridge_req};
  wire [NM-1:0] eligible = req_all & ~masked & ((locked_ff && bus_lock) ? lock_owner_ff : {NM{1'b1}});
  wire [NM-1:0] winner   = pick(eligible);
  wire [NM-1:0] parked   = park_en ? {{(NM-2){1'b0}}, 2'b10} : '0;
  wire [NM-1:0] nxt_gnt  = (eligible != '0) ? winner : parked;
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      gnt_n_ff           <= '1;
      BUS_DRIVE_OE_N_OUT <= 1'b1;
    end else if (bus_idle) begin
      gnt_n_ff           <= ~nxt_gnt;
      BUS_DRIVE_OE_N_OUT <= (nxt_gnt != '0);
    end
  end
  assign GNT_N_OUT      = gnt_n_ff[NM-1:2];
  assign HOST_GNT_N_OUT = gnt_n_ff[1];

  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RST_N_IN);

  chk_park_host_grant: assert property (bus_idle && park_en && eligible == '0 |=> !HOST_GNT_N_OUT)
    else $error("idle bus with park set did not grant host");
  chk_idle_self_drive: assert property (bus_idle && !park_en && eligible == '0 |=> !BUS_DRIVE_OE_N_OUT)
    else $error("idle bus without park not driven by bridge");
  chk_bus_lock_only: assert property (bus_idle && locked_ff && bus_lock |=> (gnt & ~lock_owner_ff) == '0)
    else $error("agent other than lock owner granted under bus lock");
  chk_masked_no_grant: assert property (bus_idle && masked[2] |=> GNT_N_OUT[0])
    else $error("masked initiator was granted");
  chk_gat_order: assert property ($rose(ISA_GNT_OUT) && guaranteed |-> $past(isa_st_ff) == ISA_GET_MEM)
    else $error("isa granted before pci and memory acquired");
  chk_isa_first: assert property (isa_st_ff == ISA_IDLE && ISA_MASTER_REQ_IN && !guaranteed |=> ISA_GNT_OUT)
    else $error("isa grant late without guaranteed access");
  chk_reserved_zero: assert property (arbiter_ctrl_ff[7:5] == 3'b000)
    else $error("arbiter control reserved bits set");
  chk_port92_decode: assert property (io_cyc && CYC_ADDR_IN == IO_PORT92 |=> CLAIM_PORT92_OUT && !CLAIM_PAGE_OUT)
    else $error("port 92h not decoded as its own register");
  chk_alias_forward: assert property (io_cyc && page_alias && CYC_ADDR_IN[15:4] == 12'h009 |=> !CLAIM_PAGE_OUT)
    else $error("90h-9Fh claimed with aliasing off");
  chk_inta_ignore: assert property (CYC_VALID_IN && CYC_INTA_IN && !intack_en |=> !CLAIM_INTA_OUT)
    else $error("inta answered while disabled");
  chk_forward_point: assert property (FORWARD_ISA_OUT |-> $past(cyc_cnt_ff) == $past(sample_clk))
    else $error("forward outside selected sample point");

endmodule

// ### hdl/bridge_ctl_pkg.sv
/*
  Shared constants and types for the bridge control and arbiter block:
  register map, field positions, reset values, cycle counts, states, carriers.
  Assumes a single 200 MHz clock domain and 32-bit AHB-Lite register access.
*/
package bridge_ctl_pkg;

  // register map: printed offsets are indices, byte address is four times
  localparam logic [7:0]  IDX_BRIDGE_CTRL  = 8'h40;
  localparam logic [7:0]  IDX_ARBITER_CTRL = 8'h41;
  localparam logic [31:0] ADDR_BRIDGE_CTRL  = 32'h0000_0100;
  localparam logic [31:0] ADDR_ARBITER_CTRL = 32'h0000_0104;

  // reset values
  localparam logic [7:0] RST_BRIDGE_CTRL  = 8'h20;
  localparam logic [7:0] RST_ARBITER_CTRL = 8'h00;

  // bridge control fields
  localparam int BIT_DMA_LINEBUF   = 0;
  localparam int BIT_ISA_LINEBUF   = 1;
  localparam int BIT_POSTED_WR_EN  = 2;
  localparam int POS_SAMPLE_POINT  = 3;
  localparam int BIT_INTACK_EN     = 5;
  localparam int BIT_PAGE_ALIAS    = 6;
  localparam logic [7:0] MASK_BRIDGE_CTRL  = 8'h7f;

  // arbiter control fields
  localparam int BIT_GUARANTEED    = 0;
  localparam int BIT_LOCK_SCOPE    = 1;
  localparam int BIT_BUS_PARK      = 2;
  localparam int POS_RETRY_TIMER   = 3;
  localparam logic [7:0] MASK_ARBITER_CTRL = 8'h1f;

  // sample point encodings and clocks after the address phase
  localparam logic [1:0] SUBTRACTIVE_SAMPLE_POINT_SLOW    = 2'b00;
  localparam logic [1:0] SUBTRACTIVE_SAMPLE_POINT_TYPICAL = 2'b01;
  localparam logic [1:0] SUBTRACTIVE_SAMPLE_POINT_FAST    = 2'b10;
  localparam logic [2:0] CLK_SUBTRACTIVE_SAMPLE_POINT_FAST    = 3'd2;
  localparam logic [2:0] CLK_SUBTRACTIVE_SAMPLE_POINT_TYPICAL = 3'd3;
  localparam logic [2:0] CLK_SUBTRACTIVE_SAMPLE_POINT_SLOW    = 3'd4;

  // retry unmask intervals in MCLK_IN clocks
  localparam logic [6:0] RETRY_CLK_16 = 7'd16;
  localparam logic [6:0] RETRY_CLK_32 = 7'd32;
  localparam logic [6:0] RETRY_CLK_64 = 7'd64;

  // i/o decode ranges
  localparam logic [15:0] IO_PAGE_BASE  = 16'h0080;
  localparam logic [15:0] IO_PORT92     = 16'h0092;
  localparam logic [15:0] IO_PIC1_BASE  = 16'h0020;
  localparam logic [15:0] IO_PIC2_BASE  = 16'h00a0;

  // isa master hand-off sequence
  typedef enum logic [2:0] {ISA_IDLE, ISA_GET_PCI, ISA_GET_MEM, ISA_OWNED, ISA_LATE_PCI} isa_state_t;

  // synchronised pci bus status, active high
  typedef struct packed {
    logic frame;
    logic irdy;
    logic trdy;
    logic stop;
    logic devsel;
    logic lock;
  } pci_bus_t;

endpackage

// ### hdl/retry_mask.sv
/*
  Per-initiator retry masking: after a retry the request is held out of
  arbitration for a selected number of clocks.
  Assumes retry pulses are one cycle wide and on the same clock.
*/
`timescale 1ns/1ps
module retry_mask
  import bridge_ctl_pkg::*;
#(
  parameter int NREQ = 4
) (
  input  wire logic            clk_in,
  input  wire logic            rst_n_in,
  input  wire logic [1:0]      timer_sel_in,
  input  wire logic [NREQ-1:0] retry_in,
  output logic      [NREQ-1:0] masked_out
);

  logic [6:0] cnt_ff [NREQ];

  // interval for the selected timer field, zero when disabled
  function automatic logic [6:0] interval(input logic [1:0] sel);
    case (sel)
      2'b01:   interval = RETRY_CLK_16;
      2'b10:   interval = RETRY_CLK_32;
      2'b11:   interval = RETRY_CLK_64;
      default: interval = 7'h00;
    endcase
  endfunction

  // first retry loads the interval, further retries while masked are ignored
  for (genvar i = 0; i < NREQ; i++) begin : g_cnt
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        cnt_ff[i] <= 7'h00;
      end else if (cnt_ff[i] != 7'h00) begin
        cnt_ff[i] <= cnt_ff[i] - 7'd1;
      end else if (retry_in[i]) begin
        cnt_ff[i] <= interval(timer_sel_in);
      end
    end
    assign masked_out[i] = (cnt_ff[i] != 7'h00);
  end

endmodule

// ### tb/pci_agents_model.sv
/*
  Partner model of the pci side: initiators that request, run a short
  transfer on their grant, and a target that answers normally or with retry;
  also the memory bus owner that grants after a prompt or slow delay.
  Assumes grants active low, driven on the same clock.
*/
`timescale 1ns/1ps
module pci_agents_model (
  input  wire logic       clk_in,
  input  wire logic [3:0] want_in,
  input  wire logic [3:0] gnt_n_in,
  input  wire logic       retry_in,
  input  wire logic       slow_in,
  input  wire logic       mem_req_in,
  output logic      [3:0] req_n_out,
  output logic            frame_n_out,
  output logic            irdy_n_out,
  output logic            trdy_n_out,
  output logic            stop_n_out,
  output logic            devsel_n_out,
  output logic            mem_gnt_out
);
  int   cnt;
  int   mcnt;
  int   nxt_cnt;
  logic any_gnt;

  // start values: released control lines sit at their pull-up level
  initial begin
    cnt = 0;
    mcnt = 0;
    req_n_out = 4'hf;
    frame_n_out = 1'b1;
    irdy_n_out = 1'b1;
    trdy_n_out = 1'b1;
    stop_n_out = 1'b1;
    devsel_n_out = 1'b1;
    mem_gnt_out = 1'b0;
  end

  // a transfer starts only for an agent that wants the bus and holds a grant
  assign any_gnt = |(want_in & ~gnt_n_in);
  always_comb nxt_cnt = (cnt == 0) ? (any_gnt ? 1 : 0) : ((cnt == 5) ? 0 : cnt + 1);

  // one data phase, then three idle clocks with all lines back at the pull-up
  always @(posedge clk_in) begin
    req_n_out <= ~want_in;
    cnt <= nxt_cnt;
    frame_n_out <= !(nxt_cnt >= 1 && nxt_cnt <= 2);
    irdy_n_out <= !(nxt_cnt >= 1 && nxt_cnt <= 3);
    devsel_n_out <= !(nxt_cnt >= 2 && nxt_cnt <= 3);
    trdy_n_out <= !(nxt_cnt == 3 && !retry_in);
    stop_n_out <= !(nxt_cnt == 3 && retry_in);
    mcnt <= mem_req_in ? ((mcnt < 9) ? mcnt + 1 : mcnt) : 0;
    mem_gnt_out <= mem_req_in && (mcnt >= (slow_in ? 8 : 1));
  end
endmodule

// ### tb/pci_arbiter_bridge_control_tb.sv
/*
  Self-checking bench for bridge_arbiter_ctl: registers, cycle decode, grants,
  parking, retry masking and isa hand-off.
  Assumes pci_agents_model on the pci side and the bench as bus master.
*/
`timescale 1ns/1ps
module pci_arbiter_bridge_control_tb;
  import bridge_ctl_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0, hwrite = 1'b0, hready, hresp;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  logic [31:0] lfsr = 32'h1ca0;
  logic [3:0]  want = 4'h0, req_n, gnt_n, cq[$];
  logic [31:0] rq[$];
  logic        host_req_n = 1'b1, lock_n = 1'b1, retry = 1'b0, slow = 1'b0, isa_req = 1'b0;
  logic        frame_n, irdy_n, trdy_n, stop_n, devsel_n, mem_gnt, mem_req, host_gnt_n, oe_n, isa_gnt;
  logic        cyc_valid = 1'b0, cyc_io = 1'b0, cyc_inta = 1'b0;
  logic [15:0] cyc_addr = '0;
  logic        c_page, c_p92, c_pic, c_inta, fwd, posted_write_buffer_enable, isa_master_linebuf_mode, dmalb, rd_dph = 1'b0, cyc_dph = 1'b0, seen;
  int          err_total = 0;
  int          num_checks = 0;
  int          i;
  int          nfr = 0, nfw = 0;
  logic        frame_q = 1'b1;

  // 200 MHz clock
  always #2.5 clk = ~clk;

  bridge_arbiter_ctl #(.NEXT(4)) uut (
    .MCLK_IN(clk), .RST_N_IN(rst_n), .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans),
    .HWRITE_IN(hwrite), .HSIZE_IN(3'b010), .HWDATA_IN(hwdata), .HREADY_IN(hready),
    .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .HRDATA_OUT(hrdata), .REQ_N_IN(req_n),
    .HOST_REQUEST_LINE_N_IN(host_req_n), .FRAME_N_IN(frame_n), .IRDY_N_IN(irdy_n),
    .TRDY_N_IN(trdy_n), .STOP_N_IN(stop_n), .DEVSEL_N_IN(devsel_n), .LOCK_N_IN(lock_n),
    .ISA_MASTER_REQ_IN(isa_req), .MEM_GNT_IN(mem_gnt), .CYC_VALID_IN(cyc_valid), .CYC_IO_IN(cyc_io),
    .CYC_INTA_IN(cyc_inta), .CYC_ADDR_IN(cyc_addr), .GNT_N_OUT(gnt_n), .HOST_GNT_N_OUT(host_gnt_n),
    .BUS_DRIVE_OE_N_OUT(oe_n), .ISA_GNT_OUT(isa_gnt), .MEM_REQ_OUT(mem_req), .CLAIM_PAGE_OUT(c_page),
    .CLAIM_PORT92_OUT(c_p92), .CLAIM_PIC_OUT(c_pic), .CLAIM_INTA_OUT(c_inta), .FORWARD_ISA_OUT(fwd),
    .POSTED_WRITE_BUFFER_ENABLE_OUT(posted_write_buffer_enable), .ISA_MASTER_LINEBUF_MODE_OUT(isa_master_linebuf_mode),
    .DMA_LINEBUF_MODE_OUT(dmalb));

  pci_agents_model agents (
    .clk_in(clk), .want_in(want), .gnt_n_in(gnt_n), .retry_in(retry), .slow_in(slow),
    .mem_req_in(mem_req), .req_n_out(req_n), .frame_n_out(frame_n), .irdy_n_out(irdy_n),
    .trdy_n_out(trdy_n), .stop_n_out(stop_n), .devsel_n_out(devsel_n), .mem_gnt_out(mem_gnt));

  // compare one result and count it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // next value of the stimulus shift register
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    lfsr_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // verdict and end of run
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // bounded wait for ready at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h0, 32'h1);
  endtask

  // single ahb-lite transfer: address phase, then data phase
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    rq.push_back(e);
    ahb(1'b0, a, 32'h0);
  endtask

  // one decoded pci cycle; claims expected as {page, port92, pic, inta}
  task automatic cyc(input logic io, input logic ia, input logic [15:0] a, input logic [3:0] e);
    cq.push_back(e);
    @(posedge clk);
    cyc_valid <= 1'b1;
    cyc_io <= io;
    cyc_inta <= ia;
    cyc_addr <= a;
    @(posedge clk);
    cyc_valid <= 1'b0;
    @(posedge clk);
  endtask

  task automatic modes(input logic [2:0] e);
    repeat (2) @(posedge clk);
    #1;
    chk({29'h0, posted_write_buffer_enable, isa_master_linebuf_mode, dmalb}, {29'h0, e});
  endtask

  // frames of initiator 0 against subtractive forwards for one sample point
  task automatic fwd_run(input logic [31:0] ctl, input logic fwd_on);
    repeat (12) @(posedge clk);
    ahb(1'b1, ADDR_BRIDGE_CTRL, ctl);
    nfr = 0;
    nfw = 0;
    want <= 4'h1;
    repeat (30) @(posedge clk);
    want <= 4'h0;
    repeat (12) @(posedge clk);
    chk({31'h0, nfr > 0}, 32'h1);
    chk(nfw, fwd_on ? nfr : 0);
  endtask

  // monitor: read data and claims are matched against the oldest note
  always @(posedge clk) begin
    if (rd_dph && hready) chk(hrdata, rq.pop_front());
    if (rd_dph && hready) chk({31'h0, hresp}, 32'h0);
    if (cyc_dph) chk({28'h0, c_page, c_p92, c_pic, c_inta}, {28'h0, cq.pop_front()});
    if (fwd) nfw++;
    if (frame_q && !frame_n) nfr++;
    rd_dph <= hsel && htrans[1] && !hwrite && hready;
    cyc_dph <= cyc_valid;
    frame_q <= frame_n;
  end

  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(ADDR_BRIDGE_CTRL, {24'h0, RST_BRIDGE_CTRL});
    rd(ADDR_ARBITER_CTRL, {24'h0, RST_ARBITER_CTRL});
    modes(3'b000);
    ahb(1'b1, ADDR_ARBITER_CTRL, 32'hffff_ffe0);
    rd(ADDR_ARBITER_CTRL, 32'h0);
    rd(32'h0000_0108, 32'h0);
    for (int k = 0; k < 4; k++) begin
      lfsr = lfsr_next(lfsr);
      ahb(1'b1, ADDR_BRIDGE_CTRL, lfsr);
      rd(ADDR_BRIDGE_CTRL, {24'h0, lfsr[7:0] & MASK_BRIDGE_CTRL});
      modes(lfsr[2:0]);
    end
    ahb(1'b1, ADDR_BRIDGE_CTRL, 32'h20);
    cyc(1'b0, 1'b1, 16'h0000, 4'b0001);
    cyc(1'b1, 1'b0, 16'h0095, 4'b1000);
    cyc(1'b1, 1'b0, 16'h0092, 4'b0100);
    // alias off, intack off, slowest sample point, all buffer modes on
    ahb(1'b1, ADDR_BRIDGE_CTRL, 32'h47);
    cyc(1'b1, 1'b0, 16'h0095, 4'b0000);
    cyc(1'b1, 1'b0, 16'h0085, 4'b1000);
    cyc(1'b1, 1'b0, 16'h0092, 4'b0100);
    cyc(1'b0, 1'b1, 16'h0000, 4'b0000);
    cyc(1'b1, 1'b0, 16'h0021, 4'b0010);
    // parking on the host line, then the bridge drives the idle bus
    ahb(1'b1, ADDR_ARBITER_CTRL, 32'h04);
    for (i = 0; i < 20 && host_gnt_n !== 1'b0; i++) @(posedge clk);
    chk({31'h0, host_gnt_n}, 32'h0);
    ahb(1'b1, ADDR_ARBITER_CTRL, 32'h00);
    for (i = 0; i < 20 && oe_n !== 1'b0; i++) @(posedge clk);
    chk({31'h0, oe_n}, 32'h0);
    // retried initiator 0 is masked so initiator 1 wins, then 0 returns
    ahb(1'b1, ADDR_ARBITER_CTRL, 32'h08);
    retry <= 1'b1;
    want <= 4'h3;
    for (i = 0; i < 60 && gnt_n[1] !== 1'b0; i++) @(posedge clk);
    chk({31'h0, gnt_n[1]}, 32'h0);
    retry <= 1'b0;
    want <= 4'h1;
    for (i = 0; i < 100 && gnt_n[0] !== 1'b0; i++) @(posedge clk);
    chk({31'h0, gnt_n[0]}, 32'h0);
    want <= 4'h0;
    // guaranteed access: memory owned before isa grant, slow memory owner
    ahb(1'b1, ADDR_ARBITER_CTRL, 32'h01);
    slow <= 1'b1;
    isa_req <= 1'b1;
    seen = 1'b0;
    for (i = 0; i < 100 && isa_gnt !== 1'b1; i++) begin
      @(posedge clk);
      #1;
      if (mem_gnt === 1'b1) seen = 1'b1;
    end
    chk({30'h0, isa_gnt, seen}, 32'h3);
    isa_req <= 1'b0;
    for (i = 0; i < 50 && isa_gnt !== 1'b0; i++) @(posedge clk);
    chk({31'h0, isa_gnt}, 32'h0);
    ahb(1'b1, ADDR_ARBITER_CTRL, 32'h00);
    isa_req <= 1'b1;
    for (i = 0; i < 50 && isa_gnt !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk({30'h0, isa_gnt, mem_req}, 32'h2);
    isa_req <= 1'b0;
    repeat (4) @(posedge clk);
    // bus lock held by initiator 1 keeps initiator 0 out, resource lock lets it in
    ahb(1'b1, ADDR_ARBITER_CTRL, 32'h02);
    want <= 4'h2;
    for (i = 0; i < 40 && gnt_n[1] !== 1'b0; i++) @(posedge clk);
    lock_n <= 1'b0;
    repeat (15) @(posedge clk);
    want <= 4'h3;
    for (i = 0; i < 40 && gnt_n[0] !== 1'b0; i++) @(posedge clk);
    chk({30'h0, gnt_n[1:0]}, 32'h1);
    ahb(1'b1, ADDR_ARBITER_CTRL, 32'h00);
    for (i = 0; i < 40 && gnt_n[0] !== 1'b0; i++) @(posedge clk);
    chk({31'h0, gnt_n[0]}, 32'h0);
    lock_n <= 1'b1;
    want <= 4'h0;
    // fast point sees devsel still active, typical point sees it released
    fwd_run(32'h10, 1'b0);
    fwd_run(32'h08, 1'b1);
    stop_test();
  end
endmodule
